//--- src/flag_alu.sv
// arithmetic unit producing result and zero, digit carry and carry flags
`timescale 1ns/1ps
module flag_alu (
  input wire status_pkg::alu_op_t op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  output logic [7:0] result_out,
  output logic zero_out,
  output logic digit_out,
  output logic carry_out,
  output logic arith_out,
  output logic rotate_out
);
  import status_pkg::*;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] b_eff;
  logic sub;
  always_comb begin
    // inverted operand plus one keeps the nibble carry right when the low nibble is zero
    sub = (op_in == OP_SUB);
    b_eff = sub ? ~b_in : b_in;
    sum = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, sub};
    nib = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
    arith_out = (op_in == OP_ADD) || (op_in == OP_SUB);
    rotate_out = (op_in == OP_ROT_RIGHT) || (op_in == OP_ROT_LEFT);
    digit_out = nib[4];
    carry_out = sum[8];
    case (op_in)
      OP_ADD, OP_SUB: result_out = sum[7:0];
      OP_AND: result_out = a_in & b_in;
      OP_OR: result_out = a_in | b_in;
      OP_XOR: result_out = a_in ^ b_in;
      OP_ROT_RIGHT: begin
        result_out = {carry_in, a_in[7:1]};
        carry_out = a_in[0];
      end
      OP_ROT_LEFT: begin
        result_out = {a_in[6:0], carry_in};
        carry_out = a_in[7];
      end
      default: result_out = 8'h00;
    endcase
    zero_out = (result_out == 8'h00);
  end
endmodule : flag_alu

//--- src/processor_flags.sv
// processor flags register with wishbone slave and event interrupt
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module processor_flags (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [4:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic watchdog_clear_instruction_in,
  input wire logic halt_instruction_in,
  input wire logic watchdog_expiry_in,
  input wire logic [7:0] direct_addr_in,
  output logic [7:0] bank_addr_out,
  output logic [7:0] alu_result_out,
  output logic irq_out
);
  import status_pkg::*;

  // every register of the block lives in this one struct
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    alu_op_t alu_op;
    logic [7:0] result;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [31:0] rdata;
    bus_state_t bus;
  } state_t;

  localparam state_t STATE_RESET = '{
    flags: FLAGS_RESET,
    alu_a: 8'h00,
    alu_b: 8'h00,
    alu_op: OP_NONE,
    result: 8'h00,
    irq_stat: IRQ_RESET,
    irq_en: IRQ_RESET,
    rdata: 32'h00000000,
    bus: BUS_IDLE
  };

  state_t state_reg;
  state_t state_next;

  // alu outputs
  logic [7:0] res;
  logic z_f;
  logic digit_f;
  logic c_f;
  logic arith;
  logic rot;

  // bus decode
  logic req;
  logic wr_lane;
  logic rd_req;
  logic hit_flags;
  logic hit_alu;
  logic hit_evt;
  logic hit_stat;
  logic hit_en;
  logic [31:0] rd_word;

  // event sources
  logic [2:0] hw_evt;
  logic [2:0] sw_evt;
  logic [2:0] evt;

  // staged flag values
  logic [7:0] flags_sw;
  logic [7:0] flags_alu;
  logic [7:0] flags_evt;
  logic [2:0] stat_clr;

  flag_alu u_alu (
    .op_in(state_reg.alu_op),
    .a_in(state_reg.alu_a),
    .b_in(state_reg.alu_b),
    .carry_in(state_reg.flags[BIT_CARRY]),
    .result_out(res),
    .zero_out(z_f),
    .digit_out(digit_f),
    .carry_out(c_f),
    .arith_out(arith),
    .rotate_out(rot)
  );

  // a request is taken only while no ack is outstanding
  always_comb begin
    req = wb_cyc_in && wb_stb_in && (state_reg.bus == BUS_IDLE);
    wr_lane = req && wb_we_in && wb_sel_in[0];
    rd_req = req && !wb_we_in;
    hit_flags = (wb_adr_in == ADDR_FLAGS);
    hit_alu = (wb_adr_in == ADDR_ALU_OPS);
    hit_evt = (wb_adr_in == ADDR_EVT_CMD);
    hit_stat = (wb_adr_in == ADDR_IRQ_STATUS);
    hit_en = (wb_adr_in == ADDR_IRQ_ENABLE);
  end

  // pin pulses and the software event command share one path
  always_comb begin
    hw_evt = 3'h0;
    hw_evt[EVT_CLRWD] = watchdog_clear_instruction_in;
    hw_evt[EVT_HALT] = halt_instruction_in;
    hw_evt[EVT_EXPIRE] = watchdog_expiry_in;
    sw_evt = 3'h0;
    if (wr_lane && hit_evt) begin
      sw_evt = wb_dat_in[2:0];
    end
    evt = hw_evt | sw_evt;
  end

  // software write: timeout and power-down are held
  always_comb begin
    flags_sw = state_reg.flags;
    if (wr_lane && hit_flags) begin
      flags_sw[BIT_IND_BANK] = wb_dat_in[BIT_IND_BANK];
      flags_sw[BIT_BANK_HIGH] = wb_dat_in[BIT_BANK_HIGH];
      flags_sw[BIT_BANK_LOW] = wb_dat_in[BIT_BANK_LOW];
      flags_sw[BIT_ZERO] = wb_dat_in[BIT_ZERO];
      flags_sw[BIT_DIGIT] = wb_dat_in[BIT_DIGIT];
      flags_sw[BIT_CARRY] = wb_dat_in[BIT_CARRY];
    end
  end

  // an op result overrides a concurrent write to the result flags that op updates
  always_comb begin
    flags_alu = flags_sw;
    if (state_reg.alu_op != OP_NONE) begin
      if (!rot) begin
        flags_alu[BIT_ZERO] = z_f;
      end
      if (arith) begin
        flags_alu[BIT_DIGIT] = digit_f;
      end
      if (arith || rot) begin
        flags_alu[BIT_CARRY] = c_f;
      end
    end
  end

  // later lines win: clear-watchdog over halt over expiry
  always_comb begin
    flags_evt = flags_alu;
    if (evt[EVT_EXPIRE]) begin
      flags_evt[BIT_TIMEOUT] = 1'b0;
    end
    if (evt[EVT_HALT]) begin
      flags_evt[BIT_TIMEOUT] = 1'b1;
      flags_evt[BIT_POWER_DOWN] = 1'b0;
    end
    if (evt[EVT_CLRWD]) begin
      flags_evt[BIT_TIMEOUT] = 1'b1;
      flags_evt[BIT_POWER_DOWN] = 1'b1;
    end
  end

  // write one to clear
  always_comb begin
    stat_clr = 3'h0;
    if (wr_lane && hit_stat) begin
      stat_clr = wb_dat_in[2:0];
    end
  end

  // unmapped and write-only offsets read as zero
  always_comb begin
    case (wb_adr_in)
      ADDR_FLAGS: begin
        rd_word = {24'h000000, state_reg.flags};
      end
      ADDR_ALU_OPS: begin
        rd_word = {24'h000000, state_reg.result};
      end
      ADDR_IRQ_STATUS: begin
        rd_word = {29'h0000000, state_reg.irq_stat};
      end
      ADDR_IRQ_ENABLE: begin
        rd_word = {29'h0000000, state_reg.irq_en};
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.flags = flags_evt;
    // an op acts in the one cycle after its write
    state_next.alu_op = OP_NONE;
    if (wr_lane && hit_alu) begin
      state_next.alu_a = wb_dat_in[7:0];
      state_next.alu_b = wb_dat_in[15:8];
      state_next.alu_op = alu_op_t'(wb_dat_in[18:16]);
    end
    if (state_reg.alu_op != OP_NONE) begin
      state_next.result = res;
    end
    // a new event beats a clear in the same cycle, so no event is lost
    state_next.irq_stat = (state_reg.irq_stat & ~stat_clr) | evt;
    if (wr_lane && hit_en) begin
      state_next.irq_en = wb_dat_in[2:0];
    end
    if (rd_req) begin
      state_next.rdata = rd_word;
    end
    case (state_reg.bus)
      BUS_IDLE: begin
        if (req) begin
          state_next.bus = BUS_ACK;
        end
      end
      BUS_ACK: begin
        // ack lasts one cycle; a request still held then is not taken twice
        state_next.bus = BUS_IDLE;
      end
      default: begin
        state_next.bus = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_out = (state_reg.bus == BUS_ACK);
  assign wb_dat_out = state_reg.rdata;
  // bank select high is not decoded; software keeps it clear
  assign bank_addr_out = {state_reg.flags[BIT_BANK_LOW], direct_addr_in[6:0]};
  assign alu_result_out = state_reg.result;
  assign irq_out = |(state_reg.irq_stat & state_reg.irq_en);
endmodule : processor_flags

//--- src/status_pkg.sv
// constants and types for the processor flags register block
package status_pkg;
  localparam logic [4:0] ADDR_FLAGS = 5'h00;
  localparam logic [4:0] ADDR_ALU_OPS = 5'h04;
  localparam logic [4:0] ADDR_EVT_CMD = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h10;
  localparam int BIT_CARRY = 0;
  localparam int BIT_DIGIT = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_BANK_LOW = 5;
  localparam int BIT_BANK_HIGH = 6;
  localparam int BIT_IND_BANK = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h18;
  localparam int EVT_CLRWD = 0;
  localparam int EVT_HALT = 1;
  localparam int EVT_EXPIRE = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  typedef enum logic [2:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_ROT_RIGHT, OP_ROT_LEFT
  } alu_op_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage : status_pkg

//--- testbench/processor_flags_monitor.sv
// port checker for the processor flags register
`timescale 1ns/1ps
module processor_flags_monitor import status_pkg::*; (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [4:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic [7:0] direct_addr_in,
  input wire logic [7:0] bank_addr_out,
  input wire logic [7:0] alu_result_out
);
  logic tk;
  logic fw;
  assign tk = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign fw = tk && wb_we_in && wb_adr_in == ADDR_FLAGS;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_bank_low_map: assert property (bank_addr_out[6:0] == direct_addr_in[6:0])
    else $error("bank address low bits differ");
  a_bank_write: assert property (fw && wb_sel_in[0] |=>
    bank_addr_out[7] == $past(wb_dat_in[BIT_BANK_LOW])) else $error("bank bit not written");
  a_bank_hold: assert property (!fw |=> $stable(bank_addr_out[7]))
    else $error("bank bit moved");
  a_ack_answer: assert property (tk |=> wb_ack_out) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack long");
  a_ack_cause: assert property (!tk |=> !wb_ack_out) else $error("stray ack");
  a_unmapped_zero: assert property (tk && !wb_we_in && wb_adr_in[1:0] != 2'h0 |=>
    wb_dat_out == 32'h0) else $error("unmapped read not zero");
  a_add_result: assert property (tk && wb_we_in && wb_sel_in[0] && wb_adr_in == ADDR_ALU_OPS &&
    wb_dat_in[18:16] == OP_ADD |-> ##2 alu_result_out ==
    $past(wb_dat_in[7:0], 2) + $past(wb_dat_in[15:8], 2)) else $error("add result wrong");
  c_alu_op: cover property (tk && wb_we_in && wb_adr_in == ADDR_ALU_OPS);
  c_status_rd: cover property (tk && !wb_we_in && wb_adr_in == ADDR_IRQ_STATUS);
  c_bank_high: cover property (bank_addr_out[7]);
endmodule : processor_flags_monitor
bind processor_flags processor_flags_monitor u_mon (.clock_in, .sys_rst_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_sel_in, .wb_dat_out, .wb_ack_out,
  .direct_addr_in, .bank_addr_out, .alu_result_out);

//--- testbench/testbench.sv
// self-checking bench for the processor flags register
`timescale 1ns/1ps
module testbench;
  import status_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [2:0] ev = 3'h0;
  logic [7:0] dai = 8'h0, bank, res;
  int error_cnt = 0, n_compared = 0, cyc_n = 0;
  // op, a, b, result, zero/digit/carry; rows chain through carry
  logic [31:0] tbl [10] = '{32'h18080005, 32'h60200814, 32'h78000005, 32'h20505007,
    32'h3f00f007, 32'h40100013, 32'h5ff0ff03, 32'h10f01102, 32'h22510153, 32'h21021ef0};
  always #5 clock_in = ~clock_in;
  processor_flags u_dut (.clock_in, .sys_rst_in, .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wd), .wb_sel_in(sel), .wb_dat_out(rdat),
    .wb_ack_out(ack), .watchdog_clear_instruction_in(ev[0]), .halt_instruction_in(ev[1]),
    .watchdog_expiry_in(ev[2]), .direct_addr_in(dai), .bank_addr_out(bank),
    .alu_result_out(res), .irq_out(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    @(posedge clock_in);
    while (ack !== 1'b1) @(posedge clock_in);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task rd(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(q, e);
  endtask : rd
  // one-cycle event pulse on the watchdog/halt inputs
  task evt(input int i);
    @(posedge clock_in);
    ev[i] <= 1'b1;
    @(posedge clock_in);
    ev <= 3'h0;
  endtask : evt
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // a hung handshake ends here
  always @(posedge clock_in) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(ADDR_FLAGS, 32'h18);
    wb(1'b1, ADDR_FLAGS, 32'hff, 4'he);
    rd(ADDR_FLAGS, 32'h18);
    wb(1'b1, ADDR_FLAGS, 32'h27, 4'h1);
    rd(ADDR_FLAGS, 32'h3f);
    dai <= 8'h85;
    @(posedge clock_in);
    chk(bank, 8'h85);
    wb(1'b1, ADDR_FLAGS, 32'h00, 4'h1);
    chk(bank, 8'h05);
    evt(EVT_HALT);
    rd(ADDR_FLAGS, 32'h10);
    evt(EVT_EXPIRE);
    rd(ADDR_FLAGS, 32'h00);
    evt(EVT_CLRWD);
    rd(ADDR_FLAGS, 32'h18);
    wb(1'b1, ADDR_EVT_CMD, 32'h4, 4'h1);
    rd(ADDR_FLAGS, 32'h08);
    evt(EVT_CLRWD);
    foreach (tbl[i]) begin
      wb(1'b1, ADDR_ALU_OPS, {13'h0, tbl[i][30:28], tbl[i][19:12], tbl[i][27:20]}, 4'h1);
      rd(ADDR_ALU_OPS, {24'h0, tbl[i][11:4]});
      chk(res, tbl[i][11:4]);
      rd(ADDR_FLAGS, {27'h3, tbl[i][2:0]});
    end
    rd(ADDR_IRQ_STATUS, 32'h7);
    wb(1'b1, ADDR_IRQ_STATUS, 32'h7, 4'h1);
    rd(ADDR_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    wb(1'b1, ADDR_IRQ_ENABLE, 32'h2, 4'h1);
    rd(ADDR_IRQ_ENABLE, 32'h2);
    evt(EVT_HALT);
    @(posedge clock_in);
    chk(irq, 1'b1);
    rd(ADDR_FLAGS, 32'h10);
    wb(1'b1, ADDR_IRQ_STATUS, 32'h2, 4'h1);
    chk(irq, 1'b0);
    rd(5'h02, 32'h0);
    close_out();
  end
endmodule : testbench
